/* hdl/tcd_pkg.sv */
// shared constants for the training command decoder
package tcd_pkg;
    // command pattern on the first link edge, lines 4..0
    localparam logic [4:0] MPC_FIRST_CODE  = 5'h00;
    localparam logic [4:0] CAS2_FIRST_CODE = 5'h12;
    // seven-bit operand codes
    localparam logic [6:0] OP_FIFO_READ    = 7'h41;
    localparam logic [6:0] OP_READ_CAL     = 7'h43;
    localparam logic [6:0] OP_FIFO_WRITE   = 7'h47;
    localparam logic [6:0] OP_OSC_START    = 7'h4B;
    localparam logic [6:0] OP_OSC_STOP     = 7'h4D;
    localparam logic [6:0] OP_ZQ_START     = 7'h4F;
    localparam logic [6:0] OP_ZQ_LATCH     = 7'h51;
    localparam int         OP6_BIT         = 6;
    // burst lengths
    localparam logic [5:0] BURST_16        = 6'h10;
    localparam logic [5:0] BURST_32        = 6'h20;
    localparam logic [1:0] BL_CFG_32       = 2'h1;
    // leveling feedback window, ns and cycles at 125 MHz
    localparam real        CLK_PERIOD_NS   = 8.0;
    localparam real        LVL_FB_MAX_NS   = 20.0;
    localparam int         LVL_FB_MAX_CYC  =
        (int'(LVL_FB_MAX_NS / CLK_PERIOD_NS - 0.5) < 1) ? 1 :
        int'(LVL_FB_MAX_NS / CLK_PERIOD_NS - 0.5);
    // reset values
    localparam logic [7:0] LVL_DQ_RST      = 8'h00;
    localparam logic [1:0] SYNC_RST        = 2'h0;
    typedef enum logic [3:0] {
        TCD_IDLE = 4'b0001,
        TCD_MPC2 = 4'b0010,
        TCD_CAS1 = 4'b0100,
        TCD_CAS2 = 4'b1000
    } tcd_state_t;
    typedef enum logic [1:0] {
        TCD_PEND_RD  = 2'h0,
        TCD_PEND_CAL = 2'h1,
        TCD_PEND_WR  = 2'h2
    } tcd_pend_t;
endpackage : tcd_pkg

/* hdl/tcd_lvl_if.sv */
// link between decoder and leveling feedback unit
`timescale 1ns/1ps
interface tcd_lvl_if;
    logic strobe_rise;
    logic clk_level;
    logic active;
    logic [7:0] dq;
    logic       dq_oe_n;
    modport ctrl (output strobe_rise, output clk_level, output active,
                  input dq, input dq_oe_n);
    modport lvl  (input strobe_rise, input clk_level, input active,
                  output dq, output dq_oe_n);
endinterface : tcd_lvl_if

/* hdl/tcd_level_fb.sv */
// write leveling feedback: clock level caught on strobe rise
`timescale 1ns/1ps
module tcd_level_fb (
    // system
    input  wire logic clk_i,
    input  wire logic rst_i,
    // decoder side
    tcd_lvl_if.lvl    lvl
);
    logic [7:0] dq_r;
    logic       oe_n_r;

    // every bit of the lane returns the same sampled level
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dq_r <= tcd_pkg::LVL_DQ_RST;
        end else if (lvl.active && lvl.strobe_rise) begin
            dq_r <= {8{lvl.clk_level}};
        end
    end

    // pins driven only while leveling; enable is active low
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            oe_n_r <= 1'b1;
        end else begin
            oe_n_r <= ~lvl.active;
        end
    end

    assign lvl.dq      = dq_r;
    assign lvl.dq_oe_n = oe_n_r;

    level_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
        lvl.active && lvl.strobe_rise |=> dq_r == {8{$past(lvl.clk_level)}})
        else $error("leveling feedback not the sampled clock level");
    level_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !lvl.strobe_rise |=> $stable(dq_r))
        else $error("leveling feedback changed without strobe edge");
endmodule : tcd_level_fb

/* hdl/tcd_decoder.sv */
// training command decoder with write leveling feedback
// Behaviour
// - leveling survives link clock stop or change
// - feedback appears four clk edges (24 to 32 ns) after strobe
// - multipurpose command spans two rising edges
// - operand bit six low means no-operation
// - latency counts from column second-half second edge
// - oscillator and calibration commands run alone
// - decode fifo read, read calibration, fifo write
// - decode oscillator stop, calibration start, latch
// - fifo trainings always use burst sixteen
// - leveling mode follows mode bit seven
// - strobe rise samples clock onto lane
`timescale 1ns/1ps
module tcd_decoder (
    // system
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // command pins from the controller
    input  wire logic       clock_pos_phase_i,
    input  wire logic       cke_i,
    input  wire logic       cs_i,
    input  wire logic [5:0] cmd_addr_lines_i,
    input  wire logic       strobe_i,
    // mode state
    input  wire logic       leveling_mode_bit_i,
    input  wire logic [1:0] burst_config_i,
    // training actions, one-cycle pulses
    output logic            fifo_read_o,
    output logic            read_cal_o,
    output logic            fifo_write_o,
    output logic [5:0]      burst_length_o,
    output logic            osc_start_o,
    output logic            osc_stop_o,
    output logic            zq_start_o,
    output logic            zq_latch_o,
    output logic            pairing_err_o,
    // leveling
    output logic            leveling_active_o,
    output logic [7:0]      level_dq_o,
    output logic            level_dq_oe_n_o
);
    localparam int NSYNC = 11;

    logic [NSYNC-1:0] meta_r;
    logic [NSYNC-1:0] sync_r;
    logic             ck_prev_r;
    logic             dqs_prev_r;
    logic             link_rise;
    logic             cmd_cke;
    logic             cmd_cs;
    logic [5:0]       cmd_ca;
    logic [6:0]       opcode;
    logic             op6_r;
    tcd_pkg::tcd_state_t state_r;
    tcd_pkg::tcd_state_t state_nxt;
    tcd_pkg::tcd_pend_t  pend_r;
    logic             lvl_r;

    tcd_lvl_if lvl_link ();

    // every pin but burst_config_i passes two flops before any logic reads it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r     <= '0;
            sync_r     <= '0;
            ck_prev_r  <= 1'b0;
            dqs_prev_r <= 1'b0;
        end else begin
            meta_r     <= {leveling_mode_bit_i, strobe_i, cmd_addr_lines_i,
                           cs_i, cke_i, clock_pos_phase_i};
            sync_r     <= meta_r;
            ck_prev_r  <= sync_r[0];
            dqs_prev_r <= sync_r[9];
        end
    end

    assign cmd_cke = sync_r[1];
    assign cmd_cs  = sync_r[2];
    assign cmd_ca  = sync_r[8:3];

    // no edge means no action: a halted link clock just pauses us
    assign link_rise = sync_r[0] & ~ck_prev_r;
    assign opcode    = {op6_r, cmd_ca};

    // leveling level follows the mode bit only, never a timeout
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lvl_r <= 1'b0;
        end else begin
            lvl_r <= sync_r[10];
        end
    end

    always_comb begin
        state_nxt = state_r;
        if (link_rise) begin
            case (state_r)
                tcd_pkg::TCD_IDLE: begin
                    if (cmd_cke && cmd_cs &&
                        cmd_ca[4:0] == tcd_pkg::MPC_FIRST_CODE) begin
                        state_nxt = tcd_pkg::TCD_MPC2;
                    end
                end
                tcd_pkg::TCD_MPC2: begin
                    state_nxt = tcd_pkg::TCD_IDLE;
                    if (cmd_cke && !cmd_cs &&
                        (opcode == tcd_pkg::OP_FIFO_READ ||
                         opcode == tcd_pkg::OP_READ_CAL ||
                         opcode == tcd_pkg::OP_FIFO_WRITE)) begin
                        state_nxt = tcd_pkg::TCD_CAS1;
                    end
                end
                tcd_pkg::TCD_CAS1: begin
                    if (cmd_cke && cmd_cs &&
                        cmd_ca[4:0] == tcd_pkg::CAS2_FIRST_CODE) begin
                        state_nxt = tcd_pkg::TCD_CAS2;
                    end else begin
                        state_nxt = tcd_pkg::TCD_IDLE;
                    end
                end
                tcd_pkg::TCD_CAS2: state_nxt = tcd_pkg::TCD_IDLE;
                default:           state_nxt = tcd_pkg::TCD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= tcd_pkg::TCD_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // operand bit six is caught on the first edge only
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            op6_r <= 1'b0;
        end else if (link_rise && state_r == tcd_pkg::TCD_IDLE) begin
            op6_r <= cmd_ca[5];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pend_r <= tcd_pkg::TCD_PEND_RD;
        end else if (link_rise && state_r == tcd_pkg::TCD_MPC2) begin
            case (opcode)
                tcd_pkg::OP_FIFO_READ:  pend_r <= tcd_pkg::TCD_PEND_RD;
                tcd_pkg::OP_READ_CAL:   pend_r <= tcd_pkg::TCD_PEND_CAL;
                tcd_pkg::OP_FIFO_WRITE: pend_r <= tcd_pkg::TCD_PEND_WR;
                default:                pend_r <= pend_r;
            endcase
        end
    end

    // column second-half operands are not checked; they must be low
    // trainings fire on the second edge so latency counts from it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fifo_read_o    <= 1'b0;
            read_cal_o     <= 1'b0;
            fifo_write_o   <= 1'b0;
            burst_length_o <= '0;
        end else begin
            fifo_read_o    <= 1'b0;
            read_cal_o     <= 1'b0;
            fifo_write_o   <= 1'b0;
            burst_length_o <= '0;
            if (link_rise && state_r == tcd_pkg::TCD_CAS2) begin
                case (pend_r)
                    tcd_pkg::TCD_PEND_RD: begin
                        fifo_read_o    <= 1'b1;
                        burst_length_o <= tcd_pkg::BURST_16;
                    end
                    tcd_pkg::TCD_PEND_WR: begin
                        fifo_write_o   <= 1'b1;
                        burst_length_o <= tcd_pkg::BURST_16;
                    end
                    default: begin
                        read_cal_o     <= 1'b1;
                        burst_length_o <=
                            (burst_config_i == tcd_pkg::BL_CFG_32) ?
                            tcd_pkg::BURST_32 : tcd_pkg::BURST_16;
                    end
                endcase
            end
        end
    end

    // stand-alone commands act on the second edge of the command
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            osc_start_o <= 1'b0;
            osc_stop_o  <= 1'b0;
            zq_start_o  <= 1'b0;
            zq_latch_o  <= 1'b0;
        end else begin
            osc_start_o <= 1'b0;
            osc_stop_o  <= 1'b0;
            zq_start_o  <= 1'b0;
            zq_latch_o  <= 1'b0;
            if (link_rise && state_r == tcd_pkg::TCD_MPC2 &&
                cmd_cke && !cmd_cs && op6_r) begin
                case (opcode)
                    tcd_pkg::OP_OSC_START: osc_start_o <= 1'b1;
                    tcd_pkg::OP_OSC_STOP:  osc_stop_o  <= 1'b1;
                    tcd_pkg::OP_ZQ_START:  zq_start_o  <= 1'b1;
                    tcd_pkg::OP_ZQ_LATCH:  zq_latch_o  <= 1'b1;
                    default:               zq_latch_o  <= 1'b0;
                endcase
            end
        end
    end

    // a broken pair is dropped, flagged for one cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pairing_err_o <= 1'b0;
        end else begin
            pairing_err_o <= link_rise && state_r == tcd_pkg::TCD_CAS1 &&
                             state_nxt == tcd_pkg::TCD_IDLE;
        end
    end

    assign lvl_link.strobe_rise = sync_r[9] & ~dqs_prev_r;
    assign lvl_link.clk_level   = sync_r[0];
    assign lvl_link.active      = lvl_r;

    tcd_level_fb u_level_fb (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .lvl   (lvl_link.lvl)
    );

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            leveling_active_o <= 1'b0;
            level_dq_o        <= tcd_pkg::LVL_DQ_RST;
            level_dq_oe_n_o   <= 1'b1;
        end else begin
            leveling_active_o <= lvl_r;
            level_dq_o        <= lvl_link.dq;
            level_dq_oe_n_o   <= lvl_link.dq_oe_n;
        end
    end

    mpc_second_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_r == tcd_pkg::TCD_MPC2 |-> $past(state_r) == tcd_pkg::TCD_IDLE
        || $past(state_r) == tcd_pkg::TCD_MPC2)
        else $error("second command edge without first");
    nop_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
        link_rise && state_r == tcd_pkg::TCD_MPC2 && !op6_r
        |=> state_r == tcd_pkg::TCD_IDLE && !osc_stop_o && !zq_start_o)
        else $error("no-operation command took action");
    pair_cas_a: assert property (@(posedge clk_i) disable iff (rst_i)
        fifo_write_o |-> $past(state_r) == tcd_pkg::TCD_CAS2)
        else $error("fifo write issued without paired command");
    fifo_burst_a: assert property (@(posedge clk_i) disable iff (rst_i)
        fifo_read_o || fifo_write_o |-> burst_length_o == 6'h10)
        else $error("fifo training burst not sixteen");
    osc_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
        link_rise && state_r == tcd_pkg::TCD_MPC2 && cmd_cke && !cmd_cs
        && opcode == 7'h4D |=> osc_stop_o && state_r == tcd_pkg::TCD_IDLE)
        else $error("oscillator stop not decoded");
    rsvd_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        link_rise && state_r == tcd_pkg::TCD_MPC2 && opcode == 7'h45
        |=> state_r == tcd_pkg::TCD_IDLE && $stable(pend_r) ##1
        !(fifo_read_o || read_cal_o || fifo_write_o))
        else $error("reserved opcode changed state");
    lvl_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
        leveling_mode_bit_i |-> ##4 leveling_active_o || $fell(sync_r[10]))
        else $error("leveling mode did not follow mode bit");
    stop_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !link_rise |=> state_r == $past(state_r))
        else $error("state moved with no link clock edge");
    lat_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
        link_rise && state_r == tcd_pkg::TCD_CAS2
        |=> fifo_read_o || read_cal_o || fifo_write_o)
        else $error("training not fired on second edge");
endmodule : tcd_decoder

/* bench/tcd_ctrl_model.sv */
// controller model: command pins, link clock and leveling strobe
`timescale 1ns/1ps
module tcd_ctrl_model (
    // system
    input  wire logic       clk_i,
    // pins toward the device
    output logic            clock_pos_phase_o,
    output logic            cke_o,
    output logic            cs_o,
    output logic [5:0]      cmd_addr_lines_o,
    output logic            strobe_o
);
    realtime half_ns = 40.0;
    logic    run_r   = 1'b0;
    time     last_edge_t;

    initial begin
        clock_pos_phase_o = 1'b0;
        cke_o = 1'b1;
        cs_o = 1'b0;
        cmd_addr_lines_o = 6'h00;
        strobe_o = 1'b0;
        last_edge_t = 0;
    end

    // link clock runs free only while leveling; parked low otherwise
    always begin
        #(half_ns);
        if (run_r) begin
            clock_pos_phase_o = ~clock_pos_phase_o;
        end
    end

    // one link edge, lines held 5 clk either side of it
    task automatic link_edge(input logic cs, input logic [5:0] ca,
                             input logic cke);
        @(negedge clk_i);
        cs_o = cs;
        cmd_addr_lines_o = ca;
        cke_o = cke;
        repeat (5) @(negedge clk_i);
        clock_pos_phase_o = 1'b1;
        last_edge_t = $time;
        repeat (5) @(negedge clk_i);
        clock_pos_phase_o = 1'b0;
        cs_o = 1'b0;
        // released lines have no pull: show the inverse
        cmd_addr_lines_o = ~ca;
    endtask : link_edge

    task automatic multipurpose_cmd(input logic [6:0] op, input logic cke);
        link_edge(1'b1, {op[6], tcd_pkg::MPC_FIRST_CODE}, cke);
        link_edge(1'b0, op[5:0], cke);
    endtask : multipurpose_cmd

    task automatic cas2();
        link_edge(1'b1, {1'b0, tcd_pkg::CAS2_FIRST_CODE}, 1'b1);
        link_edge(1'b0, 6'h00, 1'b1);
    endtask : cas2

    task automatic level_start();
        strobe_o = 1'b0;
        run_r = 1'b1;
        repeat (20) @(posedge clock_pos_phase_o);
        repeat (20) @(posedge clock_pos_phase_o);
    endtask : level_start

    // two pulses: the first rise may be missed by the device
    task automatic strobe_pair(input logic at_high);
        repeat (2) begin
            if (at_high) begin
                @(posedge clock_pos_phase_o);
            end else begin
                @(negedge clock_pos_phase_o);
            end
            // extra ns keeps the strobe off the system clock edges
            #(half_ns / 2.0 + 1.0);
            strobe_o = 1'b1;
            #(half_ns);
            strobe_o = 1'b0;
        end
        repeat (4) @(posedge clock_pos_phase_o);
    endtask : strobe_pair

    task automatic halt(input int cycles, input realtime new_half);
        run_r = 1'b0;
        @(negedge clk_i);
        clock_pos_phase_o = 1'b0;
        cs_o = 1'b0;
        repeat (cycles) @(negedge clk_i);
        half_ns = new_half;
        run_r = 1'b1;
        repeat (4) @(posedge clock_pos_phase_o);
    endtask : halt

    task automatic level_stop();
        run_r = 1'b0;
        @(negedge clk_i);
        clock_pos_phase_o = 1'b0;
    endtask : level_stop
endmodule : tcd_ctrl_model

/* bench/tcd_decoder_test.sv */
// self-checking bench for the training command decoder
`timescale 1ns/1ps
module tcd_decoder_test;
    logic       clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       leveling_mode_bit_i = 1'b0;
    logic [1:0] burst_config_i = 2'h0;
    logic       clock_pos_phase, cke, cs, strobe;
    logic [5:0] cmd_addr_lines;
    logic       fifo_read_o, read_cal_o, fifo_write_o, osc_start_o;
    logic       osc_stop_o, zq_start_o, zq_latch_o, pairing_err_o;
    logic       leveling_active_o, level_dq_oe_n_o;
    logic [5:0] burst_length_o;
    logic [7:0] level_dq_o;
    logic [7:0] seen = 8'h00;
    logic [5:0] burst_seen = 6'h00;
    time        first_t = 0;
    int         num_errors = 0;
    int         check_count = 0;
    int         cycle_cnt = 0;
    wire logic [7:0] pulse_w = {pairing_err_o, zq_latch_o, zq_start_o,
        osc_stop_o, osc_start_o, fifo_write_o, read_cal_o, fifo_read_o};

    always #4 clk_i = ~clk_i;

    tcd_ctrl_model tcd_ctrl_model_inst (.clk_i(clk_i),
        .clock_pos_phase_o(clock_pos_phase), .cke_o(cke), .cs_o(cs),
        .cmd_addr_lines_o(cmd_addr_lines), .strobe_o(strobe));

    tcd_decoder tcd_decoder_inst (.clk_i(clk_i), .rst_i(rst_i),
        .clock_pos_phase_i(clock_pos_phase), .cke_i(cke), .cs_i(cs),
        .cmd_addr_lines_i(cmd_addr_lines), .strobe_i(strobe),
        .leveling_mode_bit_i(leveling_mode_bit_i),
        .burst_config_i(burst_config_i), .fifo_read_o(fifo_read_o),
        .read_cal_o(read_cal_o), .fifo_write_o(fifo_write_o),
        .burst_length_o(burst_length_o), .osc_start_o(osc_start_o),
        .osc_stop_o(osc_stop_o), .zq_start_o(zq_start_o),
        .zq_latch_o(zq_latch_o), .pairing_err_o(pairing_err_o),
        .leveling_active_o(leveling_active_o), .level_dq_o(level_dq_o),
        .level_dq_oe_n_o(level_dq_oe_n_o));

    // gather pulses so a late or early one is still seen
    always @(posedge clk_i) begin
        cycle_cnt++;
        if ((pulse_w !== 8'h00) && (seen === 8'h00)) begin
            first_t = $time;
        end
        seen = seen | pulse_w;
        if (fifo_read_o | read_cal_o | fifo_write_o) begin
            burst_seen = burst_length_o;
        end
        if (cycle_cnt == 5000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask : check_val

    task automatic check_flag(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask : check_flag

    task automatic clear_seen();
        @(negedge clk_i);
        seen = 8'h00;
        burst_seen = 6'h00;
        first_t = 0;
    endtask : clear_seen

    task automatic run_train(input logic [6:0] op, input logic [7:0] exp,
                             input logic [5:0] bl);
        time d;
        clear_seen();
        tcd_ctrl_model_inst.multipurpose_cmd(op, 1'b1);
        repeat (8) @(negedge clk_i);
        check_val(seen, 8'h00);
        tcd_ctrl_model_inst.cas2();
        repeat (8) @(negedge clk_i);
        check_val(seen, exp);
        check_val({2'h0, burst_seen}, {2'h0, bl});
        d = first_t - tcd_ctrl_model_inst.last_edge_t;
        check_flag((d > 16) && (d <= 48), 1'b1);
    endtask : run_train

    task automatic run_alone(input logic [6:0] op, input logic [7:0] exp,
                             input logic cke_v);
        clear_seen();
        tcd_ctrl_model_inst.multipurpose_cmd(op, cke_v);
        repeat (8) @(negedge clk_i);
        check_val(seen, exp);
    endtask : run_alone

    task automatic test_training();
        @(negedge clk_i);
        burst_config_i = tcd_pkg::BL_CFG_32;
        run_train(tcd_pkg::OP_FIFO_READ, 8'h01, tcd_pkg::BURST_16);
        run_train(tcd_pkg::OP_READ_CAL, 8'h02, tcd_pkg::BURST_32);
        run_train(tcd_pkg::OP_FIFO_WRITE, 8'h04, tcd_pkg::BURST_16);
        burst_config_i = 2'h0;
        run_train(tcd_pkg::OP_READ_CAL, 8'h02, tcd_pkg::BURST_16);
        $display("test training done");
    endtask : test_training

    task automatic test_alone();
        logic [6:0] ops [4] = '{7'h4B, 7'h4D, 7'h4F, 7'h51};
        logic [7:0] exps [4] = '{8'h08, 8'h10, 8'h20, 8'h40};
        for (int i = 0; i < 4; i++) begin
            run_alone(ops[i], exps[i], 1'b1);
        end
        $display("test stand-alone done");
    endtask : test_alone

    task automatic test_refused();
        logic [6:0] ops [6] = '{7'h01, 7'h07, 7'h3F, 7'h45, 7'h49, 7'h7F};
        for (int i = 0; i < 6; i++) begin
            run_alone(ops[i], 8'h00, 1'b1);
        end
        run_alone(tcd_pkg::OP_ZQ_START, 8'h00, 1'b0);
        run_train(tcd_pkg::OP_FIFO_WRITE, 8'h04, tcd_pkg::BURST_16);
        $display("test refused done");
    endtask : test_refused

    task automatic test_pairing();
        clear_seen();
        tcd_ctrl_model_inst.multipurpose_cmd(tcd_pkg::OP_FIFO_READ, 1'b1);
        tcd_ctrl_model_inst.link_edge(1'b0, 6'h00, 1'b1);
        tcd_ctrl_model_inst.link_edge(1'b0, 6'h00, 1'b1);
        repeat (8) @(negedge clk_i);
        check_val(seen, 8'h80);
        run_train(tcd_pkg::OP_FIFO_READ, 8'h01, tcd_pkg::BURST_16);
        $display("test pairing done");
    endtask : test_pairing

    task automatic test_leveling();
        @(negedge clk_i);
        leveling_mode_bit_i = 1'b1;
        repeat (6) @(negedge clk_i);
        check_flag(leveling_active_o, 1'b1);
        check_flag(level_dq_oe_n_o, 1'b0);
        tcd_ctrl_model_inst.level_start();
        tcd_ctrl_model_inst.strobe_pair(1'b1);
        check_val(level_dq_o, 8'hFF);
        tcd_ctrl_model_inst.strobe_pair(1'b0);
        check_val(level_dq_o, 8'h00);
        tcd_ctrl_model_inst.halt(60, 60.0);
        check_flag(leveling_active_o, 1'b1);
        tcd_ctrl_model_inst.strobe_pair(1'b1);
        check_val(level_dq_o, 8'hFF);
        @(negedge clk_i);
        leveling_mode_bit_i = 1'b0;
        repeat (6) @(negedge clk_i);
        check_flag(leveling_active_o, 1'b0);
        check_flag(level_dq_oe_n_o, 1'b1);
        // strobe outside leveling must leave the lane alone
        tcd_ctrl_model_inst.strobe_pair(1'b0);
        check_val(level_dq_o, 8'hFF);
        tcd_ctrl_model_inst.level_stop();
        $display("test leveling done");
    endtask : test_leveling

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", check_count, num_errors);
        if ((num_errors == 0) && (check_count > 0)) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (5) @(negedge clk_i);
        rst_i = 1'b0;
        // let the pin synchronisers fill
        repeat (3) @(negedge clk_i);
        test_training();
        test_alone();
        test_refused();
        test_pairing();
        test_leveling();
        stop_test();
    end
endmodule : tcd_decoder_test
